// >>> logic/ipvu_defs.vh
// Constants of the interrupt poll and vector unit.
// What this block does
// - Sample pins and source flags at each opcode fetch; evaluate them on that instruction's last cycle.
// - No vectoring while an equal or higher level is in progress.
// - Vector only when polling on the final cycle of an instruction or of a vectoring call.
// - After a handler return or enable/level write, one more instruction runs first.
// - No vectoring while flash programming activity is in progress.
// - Polling is repeated on the last clock of every instruction.
// - Denied requests are not remembered; every poll starts afresh.
// - Acknowledge with a long call pushing the program counter, not the status word.
// - Each source loads its own fixed vector address, 0x0003 to 0x004b.
// - Handler return clears the current level's in-progress state and resumes.
// - A plain subroutine return leaves the in-progress state set.
// - Serial completion flags are never cleared by vectoring.
// - Vectoring clears an external flag only when it is edge triggered.
// - With edge select 0 a low pin level raises the external request.
// - With edge select 1 a high sample then a low sample sets the flag.
// - A higher request arriving early in a lower call is vectored before its first instruction.
// - Software-set counter overflow acts like hardware but needs its enable.
// - Counter 0 is served before counter 1 at the same level.
// - Higher levels preempt lower routines; never equal or lower ones.
// - Same-level ties resolve in fixed polling order, external 0 first.
// - The vectoring call lasts six clock cycles.
`ifndef IPVU_DEFS_VH
`define IPVU_DEFS_VH
`define IPVU_NSRC        10
`define IPVU_SRC_EXT0    0
`define IPVU_SRC_CNT0    1
`define IPVU_SRC_EXT1    2
`define IPVU_SRC_CNT1    3
`define IPVU_SRC_UART1   4
`define IPVU_SRC_CONV    5
`define IPVU_SRC_LVOLT   6
`define IPVU_SRC_CARRAY  7
`define IPVU_SRC_UART2   8
`define IPVU_SRC_SPERI   9
`define IPVU_VEC_BASE    16'h0003
`define IPVU_VEC_STEP    16'h0008
`define IPVU_CALL_NS     60
`define IPVU_CLK_NS      10
`define IPVU_CALL_CYC    ((`IPVU_CALL_NS + `IPVU_CLK_NS - 1) / `IPVU_CLK_NS)
`endif

// >>> logic/ipvu_ext_input.v
// External request pin conditioning: synchroniser and level or edge flag.
`timescale 1ns/1ps
module ipvu_ext_input (
  // Clock and reset
  input  wire clk,
  input  wire rst_b,
  input  wire clk_en,
  // Pin and control
  input  wire ext_request_pin,
  input  wire ext_edge_select,
  input  wire fetch_sample,
  input  wire vector_clear,
  // Result
  output wire ext_request_flag
);
  // ----------------------------------------
  // Three-stage synchroniser
  // ----------------------------------------
  reg  s1_q;
  reg  s2_q;
  reg  s3_q;
  reg  pin_q;
  reg  prev_q;
  reg  edge_flag_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q        <= 1'b1;
      s2_q        <= 1'b1;
      s3_q        <= 1'b1;
      pin_q       <= 1'b1;
      prev_q      <= 1'b1;
      edge_flag_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= ext_request_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        pin_q <= s3_q;
      end
      // Samples are compared only at fetch, so short glitches between fetches go unseen.
      if (fetch_sample) begin
        prev_q <= pin_q;
      end
      if (fetch_sample && prev_q && !pin_q && ext_edge_select) begin
        edge_flag_q <= 1'b1;
      end else if (vector_clear || !ext_edge_select) begin
        edge_flag_q <= 1'b0;
      end
    end
  end
  assign ext_request_flag = ext_edge_select ? edge_flag_q : ~pin_q;
endmodule // ipvu_ext_input

// >>> logic/ipvu_core.v
// Interrupt poll, priority resolution and vectoring sequencer.
`timescale 1ns/1ps
`include "ipvu_defs.vh"
module ipvu_core #(
  parameter NSRC     = `IPVU_NSRC,
  parameter CALL_CYC = `IPVU_CALL_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  input  wire        clk_en,
  // Processor sequencer status
  input  wire        opcode_fetch,
  input  wire        last_cycle,
  input  wire        return_from_handler,
  input  wire        plain_subroutine_return,
  input  wire        enable_level_write,
  input  wire        flash_programming_activity,
  // External pins and trigger selects
  input  wire        ext_request_pin_0,
  input  wire        ext_request_pin_1,
  input  wire        ext0_edge_select,
  input  wire        ext1_edge_select,
  // Internal source flags
  input  wire        counter0_overflow_flag,
  input  wire        counter1_overflow_flag,
  input  wire        uart1_rx_done_flag,
  input  wire        uart1_tx_done_flag,
  input  wire        conv_done_flag,
  input  wire        low_voltage_flag,
  input  wire        counter_array_request,
  input  wire        uart2_rx_done_flag,
  input  wire        uart2_tx_done_flag,
  input  wire        serial_periph_done_flag,
  // Enables and levels
  input  wire        global_enable,
  input  wire [9:0]  source_enable,
  input  wire [9:0]  level_select_low_bits,
  input  wire [9:0]  level_select_high_bits,
  // Call request to the sequencer, external request flags and clears, in-progress levels
  output reg         long_call_q,
  output reg         call_start_q,
  output reg  [15:0] vector_addr_q,
  output reg  [3:0]  vector_source_q,
  output reg         push_pc_q,
  output wire        ext0_request_flag,
  output wire        ext1_request_flag,
  output wire        ext0_flag_clear,
  output wire        ext1_flag_clear,
  output wire [3:0]  in_progress
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CALL = 2'b10;
  localparam [2:0] CALL_LAST = CALL_CYC[2:0] - 3'd1;

  reg  [1:0]      state_q;
  reg  [1:0]      state_d;
  reg  [2:0]      call_cnt_q;
  reg  [3:0]      prog_q;
  reg  [NSRC-1:0] sample_q;
  reg             fetch_seen_q;
  reg  [3:0]      win_src_d;
  reg  [1:0]      win_lvl_d;
  reg             win_any_d;
  reg  [1:0]      cur_lvl;
  reg             blocked;
  reg             clr0_q;
  reg             clr1_q;
  integer         i;

  wire [NSRC-1:0] raw_src;
  wire [NSRC-1:0] gated;
  wire            poll;
  wire            go;

  ipvu_ext_input u_ext0 (
    .clk              (clk),
    .rst_b            (rst_b),
    .clk_en           (clk_en),
    .ext_request_pin  (ext_request_pin_0),
    .ext_edge_select  (ext0_edge_select),
    .fetch_sample     (opcode_fetch),
    .vector_clear     (clr0_q),
    .ext_request_flag (ext0_request_flag)
  );
  ipvu_ext_input u_ext1 (
    .clk              (clk),
    .rst_b            (rst_b),
    .clk_en           (clk_en),
    .ext_request_pin  (ext_request_pin_1),
    .ext_edge_select  (ext1_edge_select),
    .fetch_sample     (opcode_fetch),
    .vector_clear     (clr1_q),
    .ext_request_flag (ext1_request_flag)
  );

  // ----------------------------------------
  // Source gathering in polling order
  // ----------------------------------------
  assign raw_src = {serial_periph_done_flag,
                    uart2_rx_done_flag | uart2_tx_done_flag,
                    counter_array_request,
                    low_voltage_flag,
                    conv_done_flag,
                    uart1_rx_done_flag | uart1_tx_done_flag,
                    counter1_overflow_flag,
                    ext1_request_flag,
                    counter0_overflow_flag,
                    ext0_request_flag};
  // Software-set counter flags are just inputs here, so they behave like hardware ones.
  assign gated = sample_q & source_enable & {NSRC{global_enable}};
  // A call's own last cycle is a poll point too, so a higher request sampled at call cycle 1 does not wait for a handler instruction.
  assign poll  = (state_q == ST_CALL) ? (call_cnt_q == CALL_LAST) : (last_cycle && fetch_seen_q);
  assign go    = poll && win_any_d && !blocked;
  assign in_progress = prog_q;
  assign ext0_flag_clear = clr0_q;
  assign ext1_flag_clear = clr1_q;

  // ----------------------------------------
  // Highest in-progress level and winner
  // ----------------------------------------
  always @* begin
    cur_lvl   = 2'd0;
    win_any_d = 1'b0;
    win_src_d = 4'd0;
    win_lvl_d = 2'd0;
    for (i = 0; i < 4; i = i + 1) begin
      if (prog_q[i]) begin
        cur_lvl = i[1:0];
      end
    end
    // Scan from last to first so the earliest source in polling order wins ties.
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      if (gated[i] && (!win_any_d ||
          {level_select_high_bits[i], level_select_low_bits[i]} >= win_lvl_d)) begin
        win_any_d = 1'b1;
        win_src_d = i[3:0];
        win_lvl_d = {level_select_high_bits[i], level_select_low_bits[i]};
      end
    end
    blocked = (|prog_q && (win_lvl_d <= cur_lvl))
              || (state_q == ST_IDLE && !last_cycle)
              || (last_cycle && (return_from_handler || enable_level_write))
              || flash_programming_activity;
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (go) begin
          state_d = ST_CALL;
        end
      end
      ST_CALL: begin
        if (call_cnt_q == CALL_LAST && !go) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q         <= ST_IDLE;
      call_cnt_q      <= 3'd0;
      prog_q          <= 4'h0;
      sample_q        <= {NSRC{1'b0}};
      fetch_seen_q    <= 1'b0;
      long_call_q     <= 1'b0;
      call_start_q    <= 1'b0;
      push_pc_q       <= 1'b0;
      vector_addr_q   <= 16'h0000;
      vector_source_q <= 4'h0;
      clr0_q          <= 1'b0;
      clr1_q          <= 1'b0;
    end else if (clk_en) begin
      state_q      <= state_d;
      call_start_q <= 1'b0;
      clr0_q       <= 1'b0;
      clr1_q       <= 1'b0;
      if (opcode_fetch) begin
        sample_q     <= raw_src;
        fetch_seen_q <= 1'b1;
      end
      if (state_q == ST_CALL && call_cnt_q == 3'd1) begin
        sample_q <= raw_src;
      end
      if (go) begin
        call_cnt_q      <= 3'd0;
        long_call_q     <= 1'b1;
        call_start_q    <= 1'b1;
        push_pc_q       <= 1'b1;
        vector_source_q <= win_src_d;
        vector_addr_q   <= `IPVU_VEC_BASE + {12'h000, win_src_d} * `IPVU_VEC_STEP;
        prog_q[win_lvl_d] <= 1'b1;
        // Serial flags are never cleared here; software owns them.
        clr0_q <= (win_src_d == `IPVU_SRC_EXT0) && ext0_edge_select;
        clr1_q <= (win_src_d == `IPVU_SRC_EXT1) && ext1_edge_select;
      end else if (state_q == ST_CALL) begin
        call_cnt_q <= call_cnt_q + 3'd1;
        push_pc_q  <= 1'b0;
        if (state_d == ST_IDLE) begin
          long_call_q <= 1'b0;
        end
      end
      // Only a handler return clears a level; a plain return leaves every level marked.
      if (return_from_handler && !plain_subroutine_return && last_cycle && state_q == ST_IDLE) begin
        prog_q[cur_lvl] <= 1'b0;
      end
    end
  end
endmodule // ipvu_core

// >>> tb/ipvu_core_monitor.sv
// Assertion checker on the ports of the poll and vector core.
`timescale 1ns/1ps
module ipvu_core_monitor (
  // Watched ports
  input wire        clk,
  input wire        rst_b,
  input wire        last_cycle,
  input wire        return_from_handler,
  input wire        plain_subroutine_return,
  input wire        enable_level_write,
  input wire        flash_programming_activity,
  input wire        global_enable,
  input wire        ext0_edge_select,
  input wire        long_call_q,
  input wire        call_start_q,
  input wire        push_pc_q,
  input wire [15:0] vector_addr_q,
  input wire [3:0]  vector_source_q,
  input wire        ext0_flag_clear,
  input wire [3:0]  in_progress
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_call_len: assert property (call_start_q |-> long_call_q [*6] ##1 (!long_call_q || call_start_q))
    else $error("call length");
  a_push_pc: assert property (call_start_q |-> push_pc_q && long_call_q ##1 !push_pc_q) else $error("push pulse");
  a_poll_last: assert property (call_start_q |-> $past(last_cycle) || $past(long_call_q))
    else $error("poll not on last cycle");
  a_flash_block: assert property (call_start_q |-> !$past(flash_programming_activity)) else $error("flash block");
  a_global_gate: assert property (call_start_q |-> $past(global_enable)) else $error("global gate");
  a_vector_addr: assert property (call_start_q |-> vector_addr_q == 16'h0003 + {9'h000, vector_source_q, 3'b000})
    else $error("vector address");
  // A new level is only granted above every level already running.
  a_level_above: assert property (call_start_q |-> in_progress > {$past(in_progress), 1'b0}) else $error("level");
  a_ext_clear: assert property (ext0_flag_clear |-> call_start_q && vector_source_q == 4'h0 && ext0_edge_select)
    else $error("ext clear");
  a_ret_clear: assert property (return_from_handler && last_cycle && in_progress != 4'h0 |=> in_progress < $past(in_progress))
    else $error("return clear");
  a_plain_keep: assert property (plain_subroutine_return && !return_from_handler |=>
    (in_progress & $past(in_progress)) == $past(in_progress)) else $error("plain return");
  a_hold_write: assert property ((enable_level_write || return_from_handler) && last_cycle |=> !call_start_q)
    else $error("hold after write");
  c_preempt: cover property (call_start_q && in_progress == 4'h3);
  c_edge: cover property (ext0_flag_clear);
  c_ret: cover property (return_from_handler && last_cycle);
endmodule // ipvu_core_monitor

// >>> tb/ipvu_seq_model.sv
// Behavioural model of the processor sequencer beside the poll core.
`timescale 1ns/1ps
module ipvu_seq_model (
  // Clock, reset, call and instruction kind
  input  wire clk,
  input  wire rst_b,
  input  wire long_call_q,
  input  wire kind_ret,
  input  wire kind_wr,
  // Sequencer status
  output reg  opcode_fetch,
  output reg  last_cycle,
  output wire return_from_handler,
  output wire enable_level_write
);
  // Two-cycle instructions keep every poll easy to place; longer ones are not modelled.
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      opcode_fetch <= 1'b0;
      last_cycle   <= 1'b0;
    end else if (long_call_q) begin
      opcode_fetch <= 1'b0;
      last_cycle   <= 1'b0;
    end else begin
      opcode_fetch <= ~opcode_fetch;
      last_cycle   <= opcode_fetch;
    end
  end
  assign return_from_handler = last_cycle & kind_ret;
  assign enable_level_write  = last_cycle & kind_wr;
endmodule // ipvu_seq_model

// >>> tb/ipvu_core_tb_top.sv
// Self-checking testbench of the poll and vector core.
`timescale 1ns/1ps
module ipvu_core_tb_top;
  reg         clk, rst_b, global_enable, flash_programming_activity;
  reg         ext0_edge_select, plain_subroutine_return, kind_ret, kind_wr;
  reg  [9:0]  src, source_enable, lvl_lo;
  wire        opcode_fetch, last_cycle, return_from_handler, enable_level_write;
  wire        long_call_q, call_start_q, push_pc_q, ext0_request_flag, ext0_flag_clear;
  wire [15:0] vector_addr_q;
  wire [3:0]  vector_source_q, in_progress;
  integer     failures = 0, samples_checked = 0, cyc = 0, i;
  ipvu_seq_model SEQ (.clk, .rst_b, .long_call_q, .kind_ret, .kind_wr, .opcode_fetch, .last_cycle,
    .return_from_handler, .enable_level_write);
  ipvu_core DUT (.clk, .rst_b, .clk_en(1'b1), .opcode_fetch, .last_cycle, .return_from_handler,
    .plain_subroutine_return, .enable_level_write, .flash_programming_activity, .ext0_edge_select,
    .ext_request_pin_0(~src[0]), .ext_request_pin_1(~src[2]), .ext1_edge_select(1'b0),
    .counter0_overflow_flag(src[1]), .counter1_overflow_flag(src[3]), .uart1_rx_done_flag(src[4]),
    .uart1_tx_done_flag(1'b0), .conv_done_flag(src[5]), .low_voltage_flag(src[6]),
    .counter_array_request(src[7]), .uart2_rx_done_flag(1'b0), .uart2_tx_done_flag(src[8]),
    .serial_periph_done_flag(src[9]), .global_enable, .source_enable, .level_select_low_bits(lvl_lo),
    .level_select_high_bits(10'h000), .long_call_q, .call_start_q, .vector_addr_q, .vector_source_q,
    .push_pc_q, .ext0_request_flag, .ext1_request_flag(), .ext0_flag_clear, .ext1_flag_clear(), .in_progress);
  always #5 clk = ~clk;
  task chk(input [15:0] seen, input [15:0] exp); begin
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  end endtask
  task print_verdict; begin
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  end endtask
  task wait_call(input integer lim, input exp);
    integer k;
    reg     got;
    begin
      got = 1'b0;
      for (k = 0; k < lim && !got; k = k + 1) begin
        @(posedge clk);
        #1;
        got = (call_start_q === 1'b1);
      end
      chk(got, exp);
    end
  endtask
  // The call must end before the return runs, so wait out the six call cycles first.
  task ret_instr; begin
    repeat (8) @(negedge clk);
    kind_ret = 1'b1;
    repeat (2) @(negedge clk);
    kind_ret = 1'b0;
    repeat (2) @(negedge clk);
  end endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      print_verdict;
    end
  end
  initial begin
    {clk, rst_b, kind_ret, kind_wr, flash_programming_activity, ext0_edge_select, plain_subroutine_return} = 7'h00;
    {src, lvl_lo} = 20'h00000;
    source_enable = 10'h3ff;
    global_enable = 1'b1;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    for (i = 0; i < 10; i = i + 1) begin
      src = 10'h001 << i;
      wait_call(40, 1'b1);
      chk(vector_addr_q, 16'h0003 + {i[12:0], 3'b000});
      chk(push_pc_q, 1'b1);
      chk(in_progress, 4'h1);
      @(negedge clk);
      src = 10'h000;
      ret_instr;
      chk(in_progress, 4'h0);
    end
    // Pins need their synchroniser delay, so the global enable stays off until every request is sampled.
    global_enable = 1'b0;
    src = 10'h3ff;
    repeat (8) @(negedge clk);
    global_enable = 1'b1;
    wait_call(40, 1'b1);
    chk(vector_source_q, 4'h0);
    @(negedge clk);
    src = 10'h000;
    ret_instr;
    src = 10'h00a;
    wait_call(40, 1'b1);
    chk(vector_source_q, 4'h1);
    @(negedge clk);
    src = 10'h000;
    ret_instr;
    global_enable = 1'b0;
    src = 10'h002;
    wait_call(20, 1'b0);
    @(negedge clk);
    global_enable = 1'b1;
    flash_programming_activity = 1'b1;
    wait_call(20, 1'b0);
    @(negedge clk);
    src = 10'h000;
    repeat (2) @(negedge clk);
    flash_programming_activity = 1'b0;
    wait_call(20, 1'b0);
    @(negedge clk);
    source_enable = 10'h3fd;
    src = 10'h002;
    wait_call(20, 1'b0);
    @(negedge clk);
    source_enable = 10'h3ff;
    kind_wr = 1'b1;
    repeat (2) @(negedge clk);
    kind_wr = 1'b0;
    wait_call(20, 1'b1);
    @(negedge clk);
    src = 10'h000;
    ret_instr;
    lvl_lo = 10'h002;
    src = 10'h001;
    wait_call(40, 1'b1);
    chk(ext0_request_flag, 1'b1);
    @(negedge clk);
    src = 10'h002;
    wait_call(40, 1'b1);
    chk(in_progress, 4'h3);
    @(negedge clk);
    src = 10'h010;
    wait_call(30, 1'b0);
    @(negedge clk);
    plain_subroutine_return = 1'b1;
    repeat (2) @(negedge clk);
    plain_subroutine_return = 1'b0;
    chk(in_progress, 4'h3);
    ret_instr;
    chk(in_progress, 4'h1);
    src = 10'h000;
    ret_instr;
    ext0_edge_select = 1'b1;
    repeat (4) @(negedge clk);
    src = 10'h001;
    wait_call(40, 1'b1);
    chk(ext0_flag_clear, 1'b1);
    repeat (12) @(negedge clk);
    src = 10'h000;
    ret_instr;
    wait_call(20, 1'b0);
    print_verdict;
  end
endmodule // ipvu_core_tb_top
bind ipvu_core ipvu_core_monitor u_mon (.clk, .rst_b, .last_cycle, .return_from_handler, .plain_subroutine_return,
  .enable_level_write, .flash_programming_activity, .global_enable, .ext0_edge_select, .long_call_q,
  .call_start_q, .push_pc_q, .vector_addr_q, .vector_source_q, .ext0_flag_clear, .in_progress);
